// >>> rtl/fpc_pkg.sv
// Constants and register map for the floppy rate, power and perpendicular control block
package fpc_pkg;

  // ****************************************************************
  // Register map (index and byte address on the register bus)
  // ****************************************************************
  localparam int ADR_W = 12;
  localparam logic [9:0] IDX_DOR = 10'h002; // Drive output register index
  localparam logic [9:0] IDX_DSR = 10'h004; // Rate select and power (write), main state (read)
  localparam logic [9:0] IDX_DATA = 10'h005; // Data register index
  localparam logic [9:0] IDX_CFG = 10'h010; // Command configuration index
  localparam logic [9:0] IDX_STAT = 10'h011; // Block status index
  localparam logic [9:0] IDX_CCR = 10'h3f7; // Compatibility rate control index
  localparam logic [ADR_W-1:0] ADR_DOR = {IDX_DOR, 2'b00};
  localparam logic [ADR_W-1:0] ADR_DSR = {IDX_DSR, 2'b00};
  localparam logic [ADR_W-1:0] ADR_DATA = {IDX_DATA, 2'b00};
  localparam logic [ADR_W-1:0] ADR_CFG = {IDX_CFG, 2'b00};
  localparam logic [ADR_W-1:0] ADR_STAT = {IDX_STAT, 2'b00};
  localparam logic [ADR_W-1:0] ADR_CCR = {IDX_CCR, 2'b00};

  // ****************************************************************
  // Field positions and reset values
  // ****************************************************************
  localparam int DSR_RATE_LSB = 0;
  localparam int DSR_PRE_LSB = 2;
  localparam int DSR_LP_BIT = 6;
  localparam int DSR_RST_BIT = 7;
  localparam int DOR_NRST_BIT = 2;
  localparam int CFG_PERP_BIT = 0;
  localparam int CFG_AUTO_BIT = 1;
  localparam int CFG_MLP_BIT = 2;
  localparam int CFG_OSC_BIT = 3;
  localparam int CFG_TRK_LSB = 8;
  localparam int MSR_RQM_BIT = 7;
  localparam logic [7:0] DSR_RST_VAL = 8'h00;
  localparam logic [7:0] CCR_RST_VAL = 8'h00;
  localparam logic [7:0] DOR_RST_VAL = 8'h04;
  localparam logic [15:0] CFG_RST_VAL = 16'h0000;
  localparam logic [7:0] MSR_BUSY = 8'h00;

  // ****************************************************************
  // Rate encoding, operations, format figures
  // ****************************************************************
  localparam logic [1:0] RATE_500K = 2'b00;
  localparam logic [1:0] RATE_300K = 2'b01;
  localparam logic [1:0] RATE_250K = 2'b10;
  localparam logic [1:0] RATE_1M = 2'b11;
  localparam logic [1:0] OP_NONE = 2'b00;
  localparam logic [1:0] OP_READ = 2'b01;
  localparam logic [1:0] OP_WRITE = 2'b10;
  localparam logic [1:0] OP_FORMAT = 2'b11;
  localparam logic [7:0] LEAD_1M = 8'h26; // 38 bytes
  localparam logic [7:0] LEAD_500K = 8'h13; // 19 bytes
  localparam logic [7:0] LEAD_STD = 8'h00;
  localparam logic [7:0] GAP_STD = 8'h16; // 22 bytes
  localparam logic [7:0] GAP_PERP = 8'h29; // 41 bytes

  // ****************************************************************
  // Timing
  // ****************************************************************
  localparam int CLK_NS = 4;
  localparam int BIT_NS_1M = 1000;
  localparam int BIT_NS_500K = 2000;
  localparam int BIT_NS_300K = 3333;
  localparam int BIT_NS_250K = 4000;
  localparam int SETUP_NS = 2500;
  localparam int SETUP_CYC = SETUP_NS / CLK_NS;
  localparam int AUTO_LP_MS = 500;
  localparam int AUTO_LP_CYC = AUTO_LP_MS * 1000000 / CLK_NS;
  localparam int WAKE_MS = 2;
  localparam int WAKE_CYC = WAKE_MS * 1000000 / CLK_NS;

  // Power sequencer states
  typedef enum logic [1:0] {PWR_SETUP, PWR_RUN, PWR_LOW, PWR_WAKE} fpc_pwr_e;

endpackage : fpc_pkg

// >>> rtl/fpc_ctl_if.sv
// Internal carrier between the control top and its rate and format helpers
`timescale 1ns/1ps
interface fpc_ctl_if;
  logic [1:0] rate; // Effective data rate code
  logic core_en; // Controller clock running
  logic perp; // Perpendicular mode on
  logic [1:0] op; // Current operation
  logic [7:0] bytes_to_pre; // Bytes before the data preamble
  logic me_tick; // Microengine clock enable
  logic sep_tick; // Data separator clock enable
  logic write_gate; // Write gate
  logic pre_erase; // Pre-erase active
  logic [7:0] post_id_gap; // Gap after the ID field
  modport rate_mp (input rate, input core_en, output me_tick, output sep_tick);
  modport fmt_mp (input rate, input perp, input op, input bytes_to_pre,
    output write_gate, output pre_erase, output post_id_gap);
endinterface : fpc_ctl_if

// >>> rtl/fpc_rate_clk.sv
// Rate-scaled clock enables for the microengine and data separator
`timescale 1ns/1ps
module fpc_rate_clk
  import fpc_pkg::*;
(
  // Clock, reset, enable
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  // Carrier
  fpc_ctl_if.rate_mp ctl
);
  logic [31:0] div_q; // Cycle counter within one bit cell
  logic [1:0] rate_q; // Rate seen last cycle
  logic [31:0] period; // Cycles per bit cell at the chosen rate
  logic [31:0] half; // Mid-cell point for the separator

  // Bit cell length per rate
  assign period = (ctl.rate == RATE_1M) ? 32'(BIT_NS_1M / CLK_NS) :
                  (ctl.rate == RATE_500K) ? 32'(BIT_NS_500K / CLK_NS) :
                  (ctl.rate == RATE_300K) ? 32'(BIT_NS_300K / CLK_NS) :
                  32'(BIT_NS_250K / CLK_NS);
  assign half = {1'b0, period[31:1]};
  assign ctl.me_tick = ctl.core_en && (div_q == 32'h0);
  assign ctl.sep_tick = ctl.core_en && ((div_q == 32'h0) || (div_q == half));

  // Divider restarts on a rate change so the new cell length takes hold at once
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      div_q <= 32'h0;
      rate_q <= RATE_500K;
    end
    else if (ce_i)
    begin
      rate_q <= ctl.rate;
      if ((rate_q != ctl.rate) || !ctl.core_en || (div_q >= period - 32'h1))
        div_q <= 32'h0;
      else
        div_q <= div_q + 32'h1;
    end
  end
endmodule : fpc_rate_clk

// >>> rtl/fpc_perp_fmt.sv
// Perpendicular write gate lead, pre-erase and post-ID gap selection
`timescale 1ns/1ps
module fpc_perp_fmt
  import fpc_pkg::*;
(
  // Clock, reset, enable
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  // Carrier
  fpc_ctl_if.fmt_mp ctl
);
  logic [7:0] lead; // Write gate lead in bytes
  logic wr_op; // Disk write operation under way
  logic wg_q; // Write gate flop
  logic pe_q; // Pre-erase flop
  logic [7:0] gap_q; // Gap flop

  // lead per rate in perpendicular mode
  assign lead = !ctl.perp ? LEAD_STD : (ctl.rate == RATE_1M) ? LEAD_1M : LEAD_500K;
  assign wr_op = (ctl.op == OP_WRITE) || (ctl.op == OP_FORMAT);
  assign ctl.write_gate = wg_q;
  assign ctl.pre_erase = pe_q;
  assign ctl.post_id_gap = gap_q;

  // Registered format outputs
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      wg_q <= 1'b0;
      pe_q <= 1'b0;
      gap_q <= GAP_STD;
    end
    else if (ce_i)
    begin
      wg_q <= wr_op && (ctl.bytes_to_pre <= lead);
      pe_q <= wr_op && ctl.perp && (ctl.bytes_to_pre <= lead);
      gap_q <= (ctl.perp && (ctl.rate == RATE_1M)) ? GAP_PERP : GAP_STD;
    end
  end
endmodule : fpc_perp_fmt

// >>> rtl/fpc_top.sv
// Data rate, low power and perpendicular control top with Wishbone registers
//
// Summary of operation
// - Perpendicular write gate leads by 38/19 bytes
// - Pre-erase only on format and write
// - Perpendicular 1 Mb/s gap is 41 bytes
// - Perpendicular mode bit adjusts all rates
// - Compatibility rate register takes low two bits
// - Rate select register low bits, same coding
// - Last written rate register wins
// - Rate change rescales engine and separator clocks
// - Rate indicator pins follow last rate
// - Default precompensation, changeable by rate select
// - Precompensation start track defaults to zero
// - Low power stops clock, oscillator if option
// - Power-down clears host transfer request
// - Rate select bit 6 enters low power
// - Manual low power is OR of sources
// - Auto low power after 500 ms idle
// - Software reset wakes from power-down
// - Data or state register access wakes
// - Transfer request held low until stable
// - Rate and output registers survive power-down
// - Master reset restores all defaults
// - Rate select reset self-clears, output holds
// - State register 00 then 80 within 2.5 us
`timescale 1ns/1ps
module fpc_top
  import fpc_pkg::*;
#(
  parameter int AUTO_LP_CYCLES = AUTO_LP_CYC, // Idle time before auto low power
  parameter int WAKE_CYCLES = WAKE_CYC, // Oscillator settle time after wake
  parameter int SETUP_CYCLES = SETUP_CYC, // Internal setup after reset
  parameter logic [2:0] PRECOMP_DEFAULT = 3'h0 // Default precompensation select
)
(
  // Clock, reset, enable
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  // Wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [ADR_W-1:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // Controller core side
  input wire logic ctrl_idle_i,
  input wire logic [6:0] core_msr_i,
  input wire logic [7:0] core_data_i,
  input wire logic [1:0] op_i,
  input wire logic [7:0] bytes_to_preamble_i,
  output logic [7:0] cmd_byte_o,
  output logic cmd_strobe_o,
  output logic core_reset_o,
  output logic core_clk_en_o,
  output logic osc_en_o,
  output logic me_tick_o,
  output logic sep_tick_o,
  output logic perp_mode_o,
  output logic [2:0] precomp_sel_o,
  output logic [7:0] precomp_start_track_o,
  output logic [7:0] drive_output_o,
  output logic low_power_o,
  // Drive side
  output logic write_gate_o,
  output logic pre_erase_o,
  output logic [7:0] post_id_gap_o,
  output logic rate_indicator_out0_o,
  output logic rate_indicator_out1_o
);

  // ****************************************************************
  // Declarations
  // ****************************************************************
  fpc_ctl_if ctl (); // Carrier to the helpers
  logic ack_q; // Bus answer
  logic [31:0] rdat_q; // Registered read data
  logic [7:0] dsr_q; // Rate select and power register
  logic [7:0] ccr_q; // Compatibility rate register
  logic [7:0] dor_q; // Drive output register
  logic [15:0] cfg_q; // Mode, perpendicular and configure settings
  logic [1:0] rate_q; // Effective rate
  logic [7:0] cmd_q; // Last byte written to the data register
  logic cmd_stb_q; // One-cycle command byte strobe
  fpc_pwr_e pwr_q; // Power sequencer state
  fpc_pwr_e pwr_d; // Next power state
  logic [31:0] cnt_q; // Setup, wake and idle counter
  logic [31:0] cnt_d; // Next counter value
  logic osc_off_q; // Oscillator was stopped in this power-down
  logic mlp_q; // Manual request seen last cycle

  // ****************************************************************
  // Bus decode
  // ****************************************************************
  wire req = wb_cyc_i && wb_stb_i;
  // Access completes on the edge where the answer is seen high
  wire acc = req && ack_q;
  wire wr = acc && wb_we_i;
  wire rd = acc && !wb_we_i;
  wire sel_dsr = (wb_adr_i == ADR_DSR);
  wire sel_ccr = (wb_adr_i == ADR_CCR);
  wire sel_dor = (wb_adr_i == ADR_DOR);
  wire sel_data = (wb_adr_i == ADR_DATA);
  wire sel_cfg = (wb_adr_i == ADR_CFG);
  wire sel_stat = (wb_adr_i == ADR_STAT);
  wire wr_dsr = wr && sel_dsr && wb_sel_i[0];
  wire wr_ccr = wr && sel_ccr && wb_sel_i[0];
  wire wr_dor = wr && sel_dor && wb_sel_i[0];
  wire wr_data = wr && sel_data && wb_sel_i[0];
  wire wr_cfg0 = wr && sel_cfg && wb_sel_i[0];
  wire wr_cfg1 = wr && sel_cfg && wb_sel_i[1];

  // ****************************************************************
  // Power and reset terms
  // ****************************************************************
  // rate select reset is a pulse
  wire sw_rst_dsr = wr_dsr && wb_dat_i[DSR_RST_BIT];
  // output register reset is a level
  wire sw_rst_dor = !dor_q[DOR_NRST_BIT];
  wire sw_rst = sw_rst_dsr || sw_rst_dor;
  wire mlp_req = dsr_q[DSR_LP_BIT] || cfg_q[CFG_MLP_BIT];
  // Entry on the rising request so a wake is not undone by a standing level
  wire mlp_rise = mlp_req && !mlp_q;
  wire access_wake = acc && (sel_data || (sel_dsr && !wb_we_i));
  wire in_low = (pwr_q == PWR_LOW);
  wire ready = (pwr_q == PWR_RUN);
  wire [7:0] main_state_register = ready ? {1'b1, core_msr_i} : MSR_BUSY;
  wire [31:0] stat = {16'h0, 3'h0, osc_off_q, ready, in_low, rate_q, dsr_q};
  wire [31:0] rmux = sel_dsr ? {24'h0, main_state_register} :
                     sel_ccr ? {24'h0, ccr_q} :
                     sel_dor ? {24'h0, dor_q} :
                     sel_data ? {24'h0, core_data_i} :
                     sel_cfg ? {16'h0, cfg_q} :
                     sel_stat ? stat : 32'h0;

  // ****************************************************************
  // Bus answer and read data
  // ****************************************************************
  // Answer one cycle after the request, drop the cycle after
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ack_q <= 1'b0;
      rdat_q <= 32'h0;
    end
    else if (ce_i)
    begin
      ack_q <= req && !ack_q;
      if (req && !ack_q)
        rdat_q <= rmux;
    end
  end

  // ****************************************************************
  // Host registers
  // ****************************************************************
  // Rate select register; low power bit cleared when the block wakes
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      dsr_q <= DSR_RST_VAL;
    else if (ce_i)
    begin
      if (wr_dsr)
        dsr_q <= {1'b0, wb_dat_i[6:0]};
      else if (pwr_q == PWR_WAKE)
        dsr_q[DSR_LP_BIT] <= 1'b0;
    end
  end

  // Compatibility rate and drive output registers
  // no power-state term here
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ccr_q <= CCR_RST_VAL;
      dor_q <= DOR_RST_VAL;
    end
    else if (ce_i)
    begin
      // only the low two bits act
      if (wr_ccr)
        ccr_q <= {6'h0, wb_dat_i[1:0]};
      if (wr_dor)
        dor_q <= wb_dat_i[7:0];
    end
  end

  // Effective rate follows whichever rate register was written last
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      rate_q <= RATE_500K;
    else if (ce_i)
    begin
      if (wr_dsr)
        rate_q <= wb_dat_i[DSR_RATE_LSB +: 2];
      else if (wr_ccr)
        rate_q <= wb_dat_i[1:0];
    end
  end

  // Mode, perpendicular and configure settings; a soft reset clears them
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      cfg_q <= CFG_RST_VAL;
    else if (ce_i)
    begin
      if (sw_rst)
        cfg_q <= CFG_RST_VAL;
      else
      begin
        if (wr_cfg0)
          cfg_q[7:0] <= wb_dat_i[7:0];
        if (wr_cfg1)
          cfg_q[15:8] <= wb_dat_i[15:8];
      end
    end
  end

  // Command byte strobe toward the microengine
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      cmd_q <= 8'h00;
      cmd_stb_q <= 1'b0;
    end
    else if (ce_i)
    begin
      cmd_stb_q <= wr_data && ready;
      if (wr_data)
        cmd_q <= wb_dat_i[7:0];
    end
  end

  // ****************************************************************
  // Power sequencer
  // ****************************************************************
  // Next state: setup after reset, run, low power, settle after wake
  always_comb
  begin
    pwr_d = pwr_q;
    cnt_d = cnt_q;
    case (pwr_q)
      PWR_SETUP:
      begin
        if (cnt_q >= 32'(SETUP_CYCLES - 1))
        begin
          pwr_d = PWR_RUN;
          cnt_d = 32'h0;
        end
        else
          cnt_d = cnt_q + 32'h1;
      end
      PWR_RUN:
      begin
        // idle time counted only when enabled
        if (!cfg_q[CFG_AUTO_BIT] || !ctrl_idle_i)
          cnt_d = 32'h0;
        else
          cnt_d = cnt_q + 32'h1;
        if (mlp_rise || (cnt_d >= 32'(AUTO_LP_CYCLES)))
        begin
          pwr_d = PWR_LOW;
          cnt_d = 32'h0;
        end
      end
      PWR_LOW:
      begin
        if (access_wake)
          pwr_d = PWR_WAKE;
        cnt_d = 32'h0;
      end
      PWR_WAKE:
      begin
        if (cnt_q >= 32'(osc_off_q ? WAKE_CYCLES - 1 : SETUP_CYCLES - 1))
        begin
          pwr_d = PWR_RUN;
          cnt_d = 32'h0;
        end
        else
          cnt_d = cnt_q + 32'h1;
      end
      default:
      begin
        pwr_d = PWR_SETUP;
        cnt_d = 32'h0;
      end
    endcase
  end

  // State flops; a soft reset restarts setup from any state
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      pwr_q <= PWR_SETUP;
      cnt_q <= 32'h0;
      mlp_q <= 1'b0;
    end
    else if (ce_i)
    begin
      mlp_q <= mlp_req;
      if (sw_rst)
      begin
        pwr_q <= PWR_SETUP;
        cnt_q <= 32'h0;
      end
      else
      begin
        pwr_q <= pwr_d;
        cnt_q <= cnt_d;
      end
    end
  end

  // Oscillator stop decision latched on entry
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      osc_off_q <= 1'b0;
    else if (ce_i)
    begin
      if ((pwr_q == PWR_RUN) && (pwr_d == PWR_LOW))
        osc_off_q <= cfg_q[CFG_OSC_BIT];
      else if (pwr_q == PWR_SETUP)
        osc_off_q <= 1'b0;
    end
  end

  // ****************************************************************
  // Helpers and outputs
  // ****************************************************************
  assign ctl.rate = rate_q;
  // controller clock off in low power
  assign ctl.core_en = !in_low;
  assign ctl.perp = cfg_q[CFG_PERP_BIT];
  assign ctl.op = op_i;
  assign ctl.bytes_to_pre = bytes_to_preamble_i;

  // Bit-cell clock enables
  fpc_rate_clk u_rate_clk (
    .clk_i (clk_i),
    .rst_i (rst_i),
    .ce_i (ce_i),
    .ctl (ctl.rate_mp)
  );

  // Write gate and gap logic
  fpc_perp_fmt u_perp_fmt (
    .clk_i (clk_i),
    .rst_i (rst_i),
    .ce_i (ce_i),
    .ctl (ctl.fmt_mp)
  );

  assign wb_ack_o = ack_q;
  assign wb_dat_o = rdat_q;
  assign cmd_byte_o = cmd_q;
  assign cmd_strobe_o = cmd_stb_q;
  assign core_reset_o = sw_rst || (pwr_q == PWR_SETUP);
  assign core_clk_en_o = ctl.core_en;
  assign osc_en_o = !(in_low && osc_off_q);
  assign me_tick_o = ctl.me_tick;
  assign sep_tick_o = ctl.sep_tick;
  assign perp_mode_o = cfg_q[CFG_PERP_BIT];
  assign precomp_sel_o = (dsr_q[DSR_PRE_LSB +: 3] == 3'h0) ? PRECOMP_DEFAULT
                                                           : dsr_q[DSR_PRE_LSB +: 3];
  assign precomp_start_track_o = cfg_q[CFG_TRK_LSB +: 8];
  // Motors and selects stay as software left them
  assign drive_output_o = dor_q;
  assign low_power_o = in_low;
  assign write_gate_o = ctl.write_gate;
  assign pre_erase_o = ctl.pre_erase;
  assign post_id_gap_o = ctl.post_id_gap;
  assign rate_indicator_out0_o = rate_q[0];
  assign rate_indicator_out1_o = rate_q[1];

endmodule : fpc_top

// >>> sim/fpc_top_sva.sv
// Assertion checker for the rate, power and perpendicular control top
`timescale 1ns/1ps
module fpc_top_sva
  import fpc_pkg::*;
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Bus
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [ADR_W-1:0] wb_adr_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  // Core and drive side
  input wire logic [1:0] op_i,
  input wire logic core_reset_o,
  input wire logic core_clk_en_o,
  input wire logic osc_en_o,
  input wire logic me_tick_o,
  input wire logic sep_tick_o,
  input wire logic perp_mode_o,
  input wire logic low_power_o,
  input wire logic write_gate_o,
  input wire logic pre_erase_o,
  input wire logic [7:0] post_id_gap_o,
  input wire logic rate_indicator_out0_o,
  input wire logic rate_indicator_out1_o
);
  // ****************************************************************
  // One domain: shared clock and reset
  // ****************************************************************
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // Effective rate as seen on the pins
  wire [1:0] rate = {rate_indicator_out1_o, rate_indicator_out0_o};
  // Read answer from the state register
  wire rd_msr = wb_ack_o && !wb_we_i && wb_adr_i == ADR_DSR;

  a_ack_once: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack too long");
  a_ack_next: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("ack late");
  a_gap_perp: assert property ((perp_mode_o && rate == RATE_1M)[*3] |->
    post_id_gap_o == GAP_PERP) else $error("perp gap wrong");
  a_gap_std: assert property ((!perp_mode_o || rate != RATE_1M)[*3] |->
    post_id_gap_o == GAP_STD) else $error("std gap wrong");
  a_gate_ops: assert property (write_gate_o |-> $past(op_i[1]))
    else $error("gate outside write");
  a_erase_gate: assert property (pre_erase_o |-> write_gate_o && $past(op_i[1]))
    else $error("erase outside write");
  a_lp_clock: assert property (low_power_o |->
    !core_clk_en_o && !me_tick_o && !sep_tick_o) else $error("clock runs in low power");
  a_osc_stop: assert property (!osc_en_o |-> low_power_o)
    else $error("osc off outside low power");
  a_rate_write: assert property ($changed(rate) |->
    $past(wb_ack_o) || $past(wb_ack_o, 2)) else $error("rate pins moved alone");
  a_msr_busy: assert property (rd_msr && $past(core_reset_o) |-> wb_dat_o == 32'h0)
    else $error("state not zero in setup");
  a_msr_lp: assert property (rd_msr && $past(low_power_o) |-> !wb_dat_o[MSR_RQM_BIT])
    else $error("request bit in low power");
  c_lp: cover property ($rose(low_power_o));
  c_erase: cover property (pre_erase_o);
  c_osc: cover property (!osc_en_o);
endmodule : fpc_top_sva
bind fpc_top fpc_top_sva i_fpc_top_sva (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i,
  .wb_adr_i, .wb_dat_o, .wb_ack_o, .op_i, .core_reset_o, .core_clk_en_o, .osc_en_o,
  .me_tick_o, .sep_tick_o, .perp_mode_o, .low_power_o, .write_gate_o, .pre_erase_o,
  .post_id_gap_o, .rate_indicator_out0_o, .rate_indicator_out1_o);

// >>> sim/fpc_core_model.sv
// Behavioural model of the controller core facing the control block
`timescale 1ns/1ps
module fpc_core_model
  import fpc_pkg::*;
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Commands from the bench
  input wire logic ld_i,
  input wire logic [1:0] op_i,
  input wire logic [7:0] start_i,
  // Core side of the block
  output logic [1:0] op_o,
  output logic [7:0] bytes_o,
  output logic idle_o,
  output logic [6:0] msr_o,
  output logic [7:0] dat_o
);
  // Fixed status and data so reads have a known value
  assign msr_o = 7'h10;
  assign dat_o = 8'h5a;
  assign idle_o = (op_o == OP_NONE);
  // One byte per cycle passes under the head until the preamble
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      op_o <= OP_NONE;
      bytes_o <= 8'h00;
    end
    else if (ld_i)
    begin
      op_o <= op_i;
      bytes_o <= start_i;
    end
    else if (bytes_o != 8'h00)
    begin
      bytes_o <= bytes_o - 8'h01;
    end
  end
endmodule : fpc_core_model

// >>> sim/tb_fpc_top.sv
// Register-level testbench for the rate, power and perpendicular control top
`timescale 1ns/1ps
module tb_fpc_top
  import fpc_pkg::*;
;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic cyc = 1'b0, stb = 1'b0, we = 1'b0, ack, m_ld = 1'b0;
  logic [ADR_W-1:0] adr = '0;
  logic [31:0] dat = '0, dat_o, rdat;
  logic [1:0] m_op = OP_NONE, c_op;
  logic [7:0] m_st = '0, c_bytes, c_dat, trk, gap;
  logic [6:0] c_msr;
  logic [2:0] pre;
  logic c_idle, crst, cke, osc, perp, lp, wg, pe, r0, r1;
  int n_fail = 0, n_tests = 0;

  // 250 MHz clock
  always #2 clk_i = ~clk_i;

  fpc_core_model i_fpc_core_model (.clk_i(clk_i), .rst_i(rst_i), .ld_i(m_ld), .op_i(m_op),
    .start_i(m_st), .op_o(c_op), .bytes_o(c_bytes), .idle_o(c_idle), .msr_o(c_msr),
    .dat_o(c_dat));
  fpc_top #(.AUTO_LP_CYCLES(50), .WAKE_CYCLES(20), .SETUP_CYCLES(10),
    .PRECOMP_DEFAULT(3'h3)) i_fpc_top (
    .clk_i(clk_i), .rst_i(rst_i), .ce_i(1'b1), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(dat), .wb_dat_o(dat_o), .wb_ack_o(ack),
    .ctrl_idle_i(c_idle), .core_msr_i(c_msr), .core_data_i(c_dat), .op_i(c_op),
    .bytes_to_preamble_i(c_bytes), .cmd_byte_o(), .cmd_strobe_o(), .core_reset_o(crst),
    .core_clk_en_o(cke), .osc_en_o(osc), .me_tick_o(), .sep_tick_o(), .perp_mode_o(perp),
    .precomp_sel_o(pre), .precomp_start_track_o(trk), .drive_output_o(), .low_power_o(lp),
    .write_gate_o(wg), .pre_erase_o(pe), .post_id_gap_o(gap), .rate_indicator_out0_o(r0),
    .rate_indicator_out1_o(r1));

  // ****************************************************************
  // Bus tasks and checks
  // ****************************************************************
  task automatic wrap_up();
    $display("checks %0d, mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : wrap_up

  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    n_tests++;
    if (s !== e)
    begin
      n_fail++;
      $display("[FAIL] %0t seen %h expected %h", $time, s, e);
    end
  endtask : chk

  // Classic cycle: hold the request until ack is sampled, then release
  task automatic wb(input logic w, input logic [ADR_W-1:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_i);
    cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; dat <= d;
    do begin @(posedge clk_i); n++; end while (ack !== 1'b1 && n < 50);
    rdat = dat_o;
    cyc <= 1'b0; stb <= 1'b0;
    if (n >= 50)
    begin
      n_fail++;
      wrap_up();
    end
  endtask : wb

  task automatic rd(input logic [ADR_W-1:0] a, input logic [31:0] e);
    wb(1'b0, a, 32'h0);
    chk(rdat, e);
  endtask : rd

  task automatic settle();
    repeat (2) @(posedge clk_i);
    #1;
  endtask : settle

  // Poll the state register until it reports ready; bounded
  task automatic rdy();
    rdat = '0;
    for (int i = 0; i < 100 && rdat[7] !== 1'b1; i++) wb(1'b0, ADR_DSR, 32'h0);
    chk(rdat, 32'h90);
  endtask : rdy

  // ****************************************************************
  // Test sequence
  // ****************************************************************
  initial
  begin
    repeat (12) @(posedge clk_i);
    rst_i <= 1'b0;
    rd(ADR_DSR, 32'h0);
    rd(ADR_DOR, 32'h4);
    rd(12'h100, 32'h0);
    chk(pre, 3'h3);
    chk(trk, 8'h0);
    rdy();
    $display("test 1 done");
    for (int i = 0; i < 4; i++)
    begin
      wb(1'b1, ADR_CCR, 32'(i)); settle(); chk(32'({r1, r0}), 32'(i));
      wb(1'b1, ADR_DSR, 32'(3 - i)); settle(); chk(32'({r1, r0}), 32'(3 - i));
    end
    rd(ADR_STAT, 32'h800);
    $display("test 2 done");
    wb(1'b1, ADR_DSR, 32'h17);
    wb(1'b1, ADR_CFG, 32'h701);
    settle();
    chk(pre, 3'h5);
    chk(trk, 8'h7);
    chk(perp, 1'b1);
    chk(gap, GAP_PERP);
    // Write gate lead at both rates, counted on the preamble byte count
    for (int i = 0; i < 2; i++)
    begin
      wb(1'b1, ADR_CCR, i ? RATE_500K : RATE_1M);
      m_ld <= 1'b1; m_op <= OP_WRITE; m_st <= 8'h30;
      @(posedge clk_i);
      m_ld <= 1'b0;
      for (int n = 0; n < 60 && c_bytes !== (i ? LEAD_500K : LEAD_1M); n++)
      begin
        @(posedge clk_i);
        #1;
      end
      chk(c_bytes, i ? LEAD_500K : LEAD_1M);
      chk(wg, 1'b0);
      @(posedge clk_i);
      #1;
      chk({wg, pe}, 2'b11);
    end
    chk(gap, GAP_STD);
    @(posedge clk_i);
    m_ld <= 1'b1; m_op <= OP_READ; m_st <= 8'h0;
    repeat (2) @(posedge clk_i);
    m_op <= OP_NONE;
    @(posedge clk_i);
    m_ld <= 1'b0;
    #1;
    chk({wg, pe}, 2'b00);
    $display("test 3 done");
    wb(1'b1, ADR_DOR, 32'h4);
    wb(1'b1, ADR_DSR, 32'h42);
    settle();
    chk({lp, cke, osc}, 3'b101);
    rd(ADR_STAT, 32'h642);
    rd(ADR_DSR, 32'h0);
    rdy();
    rd(ADR_STAT, 32'ha02);
    rd(ADR_CFG, 32'h701);
    wb(1'b1, ADR_CFG, 32'h70d);
    settle();
    chk({lp, osc}, 2'b10);
    wb(1'b1, ADR_DOR, 32'h0);
    settle();
    chk(lp, 1'b0);
    rd(ADR_DOR, 32'h0);
    rd(ADR_CFG, 32'h0);
    wb(1'b1, ADR_DOR, 32'h4);
    rdy();
    wb(1'b1, ADR_DSR, 32'h82);
    rd(ADR_DSR, 32'h0);
    rdy();
    chk(crst, 1'b0);
    $display("test 4 done");
    wb(1'b1, ADR_CFG, 32'h2);
    repeat (60) @(posedge clk_i);
    #1;
    chk(lp, 1'b1);
    rd(ADR_DATA, 32'h5a);
    rdy();
    repeat (40) @(posedge clk_i);
    #1;
    chk(lp, 1'b0);
    repeat (20) @(posedge clk_i);
    #1;
    chk(lp, 1'b1);
    $display("test 5 done");
    wrap_up();
  end
endmodule : tb_fpc_top
